// ### hw/sas_pkg.sv
// Shared constants and types of the SDRAM access sequencer
package sas_pkg;

  // ==========================================================================
  // Burst geometry
  localparam logic [3:0] BEATS_BUS32      = 4'h4;
  localparam logic [3:0] BEATS_BUS16      = 4'h8;
  localparam logic [3:0] USEFUL_ONE       = 4'h1;
  localparam logic [3:0] USEFUL_LONG_BUS16 = 4'h2;
  localparam int         LINE_BITS        = 128;
  localparam int         BEAT_BITS_BUS32  = 32;
  localparam int         BEAT_BITS_BUS16  = 16;

  // ==========================================================================
  // Latency and wait codes
  localparam logic [2:0] CAS_LAT_ONE      = 3'h1;
  localparam logic [2:0] CODE_MAX_CYCLES  = 3'h3;
  localparam int         TIMER_W          = 4;
  localparam int         TIMER_SLOTS      = 4;

  // ==========================================================================
  // Byte lane masks
  localparam logic [3:0] MASK_ALL         = 4'hF;
  localparam logic [3:0] MASK_NONE        = 4'h0;

  // ==========================================================================
  // Commands on the SDRAM pins
  typedef enum logic [2:0] {
    NOP_CMD                 = 3'h0,
    ACTIVATE_CMD            = 3'h1,
    FETCH_OPEN_ROW_CMD      = 3'h2,
    FETCH_AUTOPRECHARGE_CMD = 3'h3,
    STORE_OPEN_ROW_CMD      = 3'h4,
    STORE_AUTOPRECHARGE_CMD = 3'h5,
    BANK_CLOSE_CMD          = 3'h6
  } sas_cmd_t;

  // ==========================================================================
  // Access size of a request
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2,
    SIZE_LINE = 2'h3
  } sas_size_t;

  // ==========================================================================
  // Sequencer states, one-hot
  typedef enum logic [10:0] {
    ST_IDLE       = 11'h001,
    ST_CHECK      = 11'h002,
    ST_CLOSE      = 11'h004,
    ST_CLOSE_WAIT = 11'h008,
    ST_ACT        = 11'h010,
    ST_ACT_WAIT   = 11'h020,
    ST_IDLE_SLOT  = 11'h040,
    ST_CMD        = 11'h080,
    ST_CAS_WAIT   = 11'h100,
    ST_RDATA      = 11'h200,
    ST_WDATA      = 11'h400
  } sas_state_t;

endpackage : sas_pkg

// ### hw/sas_wait_timer.sv
// Per-bank precharge and recovery wait timer
module sas_wait_timer
  import sas_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = load ? load_val : ((cnt_r != '0) ? W'(cnt_r - 1'b1) : cnt_r);
  assign busy    = (cnt_r != '0);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : sas_wait_timer

// ### hw/sas_sequencer.sv
// Command sequencer for synchronous DRAM reads, writes and bank-hold mode
// ============================================================================
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int ROW_W = 13,
  parameter int COL_W = 9
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // Request side
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic                 req_write,
  input  wire logic                 req_space_two,
  input  wire sas_size_t            req_size,
  input  wire logic [3:0]           req_byte_en,
  input  wire logic                 req_bank,
  input  wire logic [ROW_W-1:0]     req_row,
  input  wire logic [COL_W-1:0]     req_col,
  input  wire logic [LINE_BITS-1:0] req_wdata,
  output logic                      done,
  output logic                      rd_valid,
  output logic [31:0]               rd_data,
  // Configuration
  input  wire logic                 burst_write_select,
  input  wire logic                 bank_hold_enable,
  input  wire logic [1:0]           write_recovery_count,
  input  wire logic [1:0]           precharge_wait_count,
  input  wire logic [1:0]           activate_delay_count,
  input  wire logic [2:0]           cas_latency,
  input  wire logic                 bus_width_32,
  // Events that close all banks
  input  wire logic                 refresh_done,
  input  wire logic                 bus_released,
  output logic [1:0]                bank_open,
  // SDRAM pins
  output sas_cmd_t                  sd_cmd,
  output logic                      sd_sel_main,
  output logic                      sd_sel_two,
  output logic                      sd_bank,
  output logic [ROW_W-1:0]          sd_addr,
  output logic [31:0]               sd_wdata,
  output logic                      sd_wdata_oe,
  output logic [3:0]                byte_lane_mask,
  input  wire logic [31:0]          sd_rdata
);

  // ==========================================================================
  // Registers
  sas_state_t             state_r,   state_nxt;
  logic [2:0]             cnt_r,     cnt_nxt;
  logic [3:0]             beat_r,    beat_nxt;
  logic                   wr_r;
  logic                   two_r;
  logic                   bank_r;
  logic [ROW_W-1:0]       row_r;
  logic [COL_W-1:0]       col_r;
  logic [3:0]             be_r;
  logic [LINE_BITS-1:0]   wdata_r;
  logic                   hold_r;
  logic                   bwrite_r;
  logic                   bus32_r;
  logic [3:0]             beats_r;
  logic [3:0]             useful_r;
  logic [1:0]             open_r;
  logic [ROW_W-1:0]       open_row_r [2];

  logic                   req_ready_r;
  logic                   done_r;
  logic                   rd_valid_r;
  logic [31:0]            rd_data_r;
  sas_cmd_t               sd_cmd_r,  sd_cmd_nxt;
  logic                   sd_sel_main_r;
  logic                   sd_sel_two_r;
  logic                   sd_bank_r;
  logic [ROW_W-1:0]       sd_addr_r, sd_addr_nxt;
  logic [31:0]            sd_wdata_r;
  logic                   sd_wdata_oe_r;
  logic [3:0]             mask_r,    mask_nxt;

  // ==========================================================================
  // Decoded timing in cycles
  wire logic [2:0] trp_cyc  = {1'b0, precharge_wait_count} + 3'h1;
  wire logic [2:0] twr_cyc  = {1'b0, write_recovery_count} + 3'h1;
  wire logic [2:0] rcd_cyc  = (activate_delay_count == 2'h3) ? CODE_MAX_CYCLES
                                : ({1'b0, activate_delay_count} + 3'h1);
  wire logic       cl_one   = (cas_latency == CAS_LAT_ONE);
  // Read tap shrinks by one once the CAS latency exceeds one cycle
  wire logic [TIMER_W-1:0] rd_tap = cl_one ? TIMER_W'(trp_cyc)
                                           : TIMER_W'(trp_cyc - 3'h1);
  wire logic [TIMER_W-1:0] wr_tap = TIMER_W'(twr_cyc) + TIMER_W'(trp_cyc);

  // ==========================================================================
  // Request acceptance and decode
  wire logic accept   = (state_r == ST_IDLE) && req_valid && req_ready_r;
  wire logic [3:0] req_beats = bus_width_32 ? BEATS_BUS32 : BEATS_BUS16;
  // Only a line fill keeps all beats; DMA units below 16 bytes arrive as smaller sizes
  wire logic [3:0] req_useful = (req_size == SIZE_LINE) ? req_beats
                              : ((req_size == SIZE_LONG) && !bus_width_32) ? USEFUL_LONG_BUS16
                              : USEFUL_ONE;
  wire logic req_hold = bank_hold_enable && !req_space_two;

  wire logic [1:0] slot_idx  = {two_r, bank_r};
  wire logic [TIMER_SLOTS-1:0] slot_busy;
  wire logic row_match = (open_row_r[bank_r] == row_r);
  wire logic is_open   = !two_r && open_r[bank_r];
  wire logic row_hit   = hold_r && is_open && row_match;
  // An open bank must be closed on a miss, or when hold mode was switched off
  wire logic need_close = is_open && !row_hit;
  wire logic wbeats_more = bwrite_r && (beats_r > 4'h1);
  wire logic last_beat  = (beat_r == 4'(beats_r - 4'h1));
  wire logic cur_useful = (beat_r < useful_r);
  wire logic rd_end     = (state_r == ST_RDATA) && last_beat;
  wire logic wr_end     = ((state_r == ST_CMD) && wr_r && !wbeats_more)
                       || ((state_r == ST_WDATA) && last_beat);

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Only this bank's own timer can hold the access back
        if (!slot_busy[slot_idx]) begin
          if (row_hit) begin
            state_nxt = (!wr_r && cl_one) ? ST_IDLE_SLOT : ST_CMD;
          end else if (need_close) begin
            state_nxt = ST_CLOSE;
          end else begin
            state_nxt = ST_ACT;
          end
        end
      end
      ST_CLOSE: begin
        state_nxt = (trp_cyc > 3'h1) ? ST_CLOSE_WAIT : ST_ACT;
      end
      ST_CLOSE_WAIT: begin
        if (cnt_r == 3'h0) begin
          state_nxt = ST_ACT;
        end
      end
      ST_ACT: begin
        state_nxt = (rcd_cyc > 3'h1) ? ST_ACT_WAIT : ST_CMD;
      end
      ST_ACT_WAIT: begin
        if (cnt_r == 3'h0) begin
          state_nxt = ST_CMD;
        end
      end
      ST_IDLE_SLOT: begin
        state_nxt = ST_CMD;
      end
      ST_CMD: begin
        if (wr_r) begin
          state_nxt = wbeats_more ? ST_WDATA : ST_IDLE;
        end else begin
          state_nxt = cl_one ? ST_RDATA : ST_CAS_WAIT;
        end
      end
      ST_CAS_WAIT: begin
        if (cnt_r == 3'h0) begin
          state_nxt = ST_RDATA;
        end
      end
      ST_RDATA: begin
        if (last_beat) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WDATA: begin
        if (last_beat) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Wait counter: loaded with delay minus two on entry to a wait state
  always_comb begin
    cnt_nxt = (cnt_r != 3'h0) ? 3'(cnt_r - 3'h1) : cnt_r;
    if ((state_nxt == ST_CLOSE_WAIT) && (state_r != ST_CLOSE_WAIT)) begin
      cnt_nxt = 3'(trp_cyc - 3'h2);
    end else if ((state_nxt == ST_ACT_WAIT) && (state_r != ST_ACT_WAIT)) begin
      cnt_nxt = 3'(rcd_cyc - 3'h2);
    end else if ((state_nxt == ST_CAS_WAIT) && (state_r != ST_CAS_WAIT)) begin
      cnt_nxt = 3'(cas_latency - 3'h2);
    end
  end

  // Write beat zero rides with the command, so the data phase starts at one
  assign beat_nxt = (state_r == ST_IDLE) ? 4'h0 : (state_r == ST_CMD) ? (wr_r ? 4'h1 : 4'h0)
                  : ((state_r == ST_RDATA) || (state_r == ST_WDATA)) ? 4'(beat_r + 4'h1)
                  : beat_r;

  // ==========================================================================
  // Command, address and mask selection
  wire sas_cmd_t rw_cmd = wr_r ? (hold_r ? STORE_OPEN_ROW_CMD : STORE_AUTOPRECHARGE_CMD)
                               : (hold_r ? FETCH_OPEN_ROW_CMD : FETCH_AUTOPRECHARGE_CMD);

  assign sd_cmd_nxt = (state_r == ST_CLOSE) ? BANK_CLOSE_CMD
                    : (state_r == ST_ACT)   ? ACTIVATE_CMD
                    : (state_r == ST_CMD)   ? rw_cmd
                    : NOP_CMD;
  assign sd_addr_nxt = (state_r == ST_ACT) ? row_r
                     : (state_r == ST_CMD) ? ROW_W'(col_r)
                     : sd_addr_r;

  wire logic wbeat  = wr_r && ((state_r == ST_CMD) || (state_r == ST_WDATA));
  wire logic [3:0] lane_en = bus32_r ? be_r : {2'b00, be_r[1:0]};
  // Empty write slots keep every lane masked so memory contents stay intact
  assign mask_nxt = !wbeat ? MASK_NONE
                  : cur_useful ? ~lane_en : MASK_ALL;

  wire logic [31:0] wbeat_data = bus32_r ? wdata_r[31:0] : {16'h0000, wdata_r[15:0]};
  wire logic [31:0] rbeat_data = bus32_r ? sd_rdata : {16'h0000, sd_rdata[15:0]};

  // ==========================================================================
  // Per-bank wait timers, one per space and bank
  wire logic [TIMER_W-1:0] tap_val  = wr_r ? wr_tap : rd_tap;
  wire logic               tap_load = !hold_r && (rd_end || wr_end);

  genvar gi;
  generate
    for (gi = 0; gi < TIMER_SLOTS; gi++) begin : g_timer
      sas_wait_timer #(
        .W        (TIMER_W)
      ) u_timer (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .load     (tap_load && (slot_idx == 2'(gi))),
        .load_val (tap_val),
        .busy     (slot_busy[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Open-row tracking for the main space banks
  wire logic close_all = refresh_done || bus_released;
  wire logic open_set  = (state_r == ST_ACT) && hold_r;
  wire logic open_clr  = (state_r == ST_CLOSE);

  generate
    for (gi = 0; gi < 2; gi++) begin : g_bank
      wire logic sel = (bank_r == 1'(gi)) && !two_r;
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          open_r[gi]     <= 1'b0;
          open_row_r[gi] <= '0;
        end else if (sel && open_set) begin
          // A bank opened in the same cycle as a close-all stays open
          open_r[gi]     <= 1'b1;
          open_row_r[gi] <= row_r;
        end else if (close_all || (sel && open_clr)) begin
          open_r[gi]     <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Request capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_r     <= 1'b0;
      two_r    <= 1'b0;
      bank_r   <= 1'b0;
      row_r    <= '0;
      col_r    <= '0;
      be_r     <= 4'h0;
      hold_r   <= 1'b0;
      bwrite_r <= 1'b0;
      bus32_r  <= 1'b1;
      beats_r  <= BEATS_BUS32;
      useful_r <= USEFUL_ONE;
    end else if (accept) begin
      wr_r     <= req_write;
      two_r    <= req_space_two;
      bank_r   <= req_bank;
      row_r    <= req_row;
      col_r    <= req_col;
      be_r     <= req_byte_en;
      hold_r   <= req_hold;
      bwrite_r <= burst_write_select;
      bus32_r  <= bus_width_32;
      // Non-burst writes count the useful beats but send only the first
      beats_r  <= (req_write && !burst_write_select) ? req_useful : req_beats;
      useful_r <= req_useful;
    end else if (wbeat && !bus32_r) begin
      be_r     <= {2'b00, be_r[3:2]};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wdata_r <= '0;
    end else if (accept) begin
      wdata_r <= req_wdata;
    end else if (wbeat) begin
      wdata_r <= bus32_r ? (wdata_r >> BEAT_BITS_BUS32) : (wdata_r >> BEAT_BITS_BUS16);
    end
  end

  // ==========================================================================
  // Sequencer and output registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r       <= ST_IDLE;
      cnt_r         <= 3'h0;
      beat_r        <= 4'h0;
      req_ready_r   <= 1'b0;
      done_r        <= 1'b0;
      rd_valid_r    <= 1'b0;
      rd_data_r     <= 32'h0000_0000;
      sd_cmd_r      <= NOP_CMD;
      sd_sel_main_r <= 1'b0;
      sd_sel_two_r  <= 1'b0;
      sd_bank_r     <= 1'b0;
      sd_addr_r     <= '0;
      sd_wdata_r    <= 32'h0000_0000;
      sd_wdata_oe_r <= 1'b0;
      mask_r        <= MASK_NONE;
    end else begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      beat_r        <= beat_nxt;
      req_ready_r   <= (state_nxt == ST_IDLE) && !accept;
      done_r        <= rd_end || wr_end;
      rd_valid_r    <= (state_r == ST_RDATA) && cur_useful;
      if ((state_r == ST_RDATA) && cur_useful) begin
        rd_data_r   <= rbeat_data;
      end
      sd_cmd_r      <= sd_cmd_nxt;
      sd_sel_main_r <= (sd_cmd_nxt != NOP_CMD) && !two_r;
      sd_sel_two_r  <= (sd_cmd_nxt != NOP_CMD) && two_r;
      sd_bank_r     <= bank_r;
      sd_addr_r     <= sd_addr_nxt;
      sd_wdata_r    <= wbeat ? wbeat_data : sd_wdata_r;
      sd_wdata_oe_r <= wbeat;
      mask_r        <= mask_nxt;
    end
  end

  assign req_ready      = req_ready_r;
  assign done           = done_r;
  assign rd_valid       = rd_valid_r;
  assign rd_data        = rd_data_r;
  assign bank_open      = open_r;
  assign sd_cmd         = sd_cmd_r;
  assign sd_sel_main    = sd_sel_main_r;
  assign sd_sel_two     = sd_sel_two_r;
  assign sd_bank        = sd_bank_r;
  assign sd_addr        = sd_addr_r;
  assign sd_wdata       = sd_wdata_r;
  assign sd_wdata_oe    = sd_wdata_oe_r;
  assign byte_lane_mask = mask_r;

endmodule : sas_sequencer

// ### verification/sas_sequencer_properties.sv
// Port-level assertions for the SDRAM access sequencer
module sas_sequencer_properties
  import sas_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       rd_valid,
  input wire logic       req_ready,
  input wire logic       burst_write_select,
  input wire logic       bank_hold_enable,
  input wire logic [1:0] activate_delay_count,
  input wire logic [2:0] cas_latency,
  input wire logic       bus_width_32,
  input wire logic       refresh_done,
  input wire logic [1:0] bank_open,
  input wire sas_cmd_t   sd_cmd,
  input wire logic       sd_sel_main,
  input wire logic       sd_sel_two,
  input wire logic       sd_wdata_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========
  // Multi-step sequences
  sequence cas_gap_s;
    !rd_valid [*2] ##1 rd_valid;
  endsequence
  sequence burst_tail_s;
    sd_wdata_oe [*3] ##1 !sd_wdata_oe;
  endsequence
  act_gap_a: assert property (sd_cmd == ACTIVATE_CMD && activate_delay_count == 2'h0
    |=> sd_cmd inside {FETCH_OPEN_ROW_CMD, FETCH_AUTOPRECHARGE_CMD, STORE_OPEN_ROW_CMD, STORE_AUTOPRECHARGE_CMD})
    else $error("activate gap");
  write_data_a: assert property (sd_cmd == STORE_AUTOPRECHARGE_CMD |-> sd_wdata_oe)
    else $error("write data");
  hold_cmds_a: assert property (bank_hold_enable && sd_sel_main
    |-> !(sd_cmd inside {FETCH_AUTOPRECHARGE_CMD, STORE_AUTOPRECHARGE_CMD})) else $error("hold cmd");
  space_two_a: assert property (sd_sel_two
    |-> !(sd_cmd inside {FETCH_OPEN_ROW_CMD, STORE_OPEN_ROW_CMD})) else $error("space two cmd");
  cas_gap_a: assert property (sd_cmd inside {FETCH_OPEN_ROW_CMD, FETCH_AUTOPRECHARGE_CMD}
    && cas_latency == 3'h2 |-> cas_gap_s) else $error("cas gap");
  refresh_close_a: assert property (refresh_done && req_ready |=> bank_open == 2'h0)
    else $error("refresh close");
  burst_tail_a: assert property (sd_cmd == STORE_AUTOPRECHARGE_CMD && burst_write_select
    && bus_width_32 |=> burst_tail_s) else $error("burst tail");
  single_write_a: assert property (sd_cmd == STORE_AUTOPRECHARGE_CMD && !burst_write_select
    |=> !sd_wdata_oe) else $error("single write");
endmodule : sas_sequencer_properties

// ### verification/sas_sdram_model.sv
// Behavioural SDRAM read data side
module sas_sdram_model
  import sas_pkg::*;
#(
  parameter logic [31:0] DATA_BASE = 32'h5A5AC300
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire sas_cmd_t   sd_cmd,
  input  wire logic [2:0] cas_latency,
  input  wire logic       bus_width_32,
  output logic [31:0]     sd_rdata
);
  logic [4:0]  age_r;
  logic [4:0]  age_nxt;
  logic [31:0] noise_r;
  wire logic       is_rd = sd_cmd inside {FETCH_OPEN_ROW_CMD, FETCH_AUTOPRECHARGE_CMD};
  wire logic [4:0] beat = (is_rd ? 5'h00 : age_r) - 5'(cas_latency) + 5'h01;
  wire logic [4:0] beats = 5'(bus_width_32 ? BEATS_BUS32 : BEATS_BUS16);
  assign age_nxt = is_rd ? 5'h01 : (age_r == 5'h00 || age_r == 5'h1F) ? age_r : age_r + 5'h01;
  // Outside a burst the lines change every cycle, so a stray capture cannot match
  assign sd_rdata = ((is_rd || age_r != 5'h00) && beat < beats) ? (DATA_BASE | 32'(beat)) : noise_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      age_r   <= 5'h00;
      noise_r <= 32'h0;
    end else begin
      age_r   <= age_nxt;
      noise_r <= {noise_r[30:0], ~noise_r[31]};
    end
  end
endmodule : sas_sdram_model

// ### verification/sas_sequencer_bench.sv
// Self-checking bench of the SDRAM access sequencer
module sas_sequencer_bench
  import sas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h5A5AC300;
  logic clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_space_two = 1'b0, req_bank = 1'b0;
  logic burst_write_select = 1'b0, bank_hold_enable = 1'b0, bus_width_32 = 1'b1, refresh_done = 1'b0;
  logic bus_released = 1'b0;
  sas_size_t req_size = SIZE_LINE;
  logic [12:0] req_row = 13'h0000;
  logic [8:0] req_col = 9'h000;
  logic [3:0] req_byte_en = 4'hF;
  logic [127:0] req_wdata = 128'h0;
  logic req_ready, done, rd_valid, sd_sel_main, sd_sel_two, sd_bank, sd_wdata_oe;
  logic [31:0] rd_data, sd_wdata, sd_rdata, first_rd, wd0;
  logic [1:0] bank_open;
  logic [12:0] sd_addr, act_addr;
  logic [3:0] byte_lane_mask;
  sas_cmd_t sd_cmd;
  int mismatches = 0, checks_done = 0, cycles = 0, n_act, n_rd, n_oe, n_mask, n_cls;
  sas_sequencer dut_u (.clk_sys, .resetn, .req_valid, .req_ready, .req_write, .req_space_two, .req_size,
    .req_byte_en, .req_bank, .req_row, .req_col, .req_wdata, .done, .rd_valid, .rd_data, .burst_write_select,
    .bank_hold_enable, .write_recovery_count(2'h1), .precharge_wait_count(2'h1), .activate_delay_count(2'h0),
    .cas_latency(3'h2), .bus_width_32, .refresh_done, .bus_released, .bank_open, .sd_cmd, .sd_sel_main,
    .sd_sel_two, .sd_bank, .sd_addr, .sd_wdata, .sd_wdata_oe, .byte_lane_mask, .sd_rdata);
  sas_sdram_model model_u (.clk_sys, .resetn, .sd_cmd, .cas_latency(3'h2), .bus_width_32, .sd_rdata);
  // ==========
  // Monitor and helpers
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (sd_cmd === ACTIVATE_CMD) begin
      n_act++;
      act_addr = sd_addr;
    end
    if (sd_cmd === BANK_CLOSE_CMD) n_cls++;
    if (sd_wdata_oe === 1'b1) begin
      if (n_oe == 0) wd0 = sd_wdata;
      n_oe++;
    end
    if (sd_wdata_oe === 1'b1 && byte_lane_mask === MASK_ALL) n_mask++;
    if (rd_valid === 1'b1) begin
      if (n_rd == 0) first_rd = rd_data;
      n_rd++;
    end
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic access(input logic wr, input sas_size_t sz, input logic bank, input logic [12:0] row);
    n_act = 0;
    n_rd = 0;
    n_oe = 0;
    n_mask = 0;
    n_cls = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_size <= sz;
    req_bank <= bank;
    req_row <= row;
    req_col <= {1'b0, row[7:0]};
    req_byte_en <= row[3:0] | 4'h1;
    req_wdata <= {8{row[7:0], 8'hC3}};
    do @(negedge clk_sys); while (req_ready !== 1'b1);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
  endtask : access
  // ==========
  // Scenarios
  task automatic t_reads();
    access(1'b0, SIZE_LINE, 1'b0, 13'h0011);
    check(32'(n_rd), 32'h4);
    check(first_rd, BASE);
    check(rd_data, BASE | 32'h3);
    for (int s = 0; s < 3; s++) begin
      access(1'b0, sas_size_t'(s), 1'b1, 13'h0022);
      check(32'(n_rd), 32'h1);
      check(rd_data, BASE);
    end
    $display("done reads");
  endtask : t_reads
  task automatic t_bus16();
    int exp_n[4] = '{1, 1, 2, 8};
    @(posedge clk_sys);
    bus_width_32 <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      access(1'b0, sas_size_t'(s), 1'b0, 13'h0033);
      check(32'(n_rd), 32'(exp_n[s]));
      check(rd_data, 32'h0000C300 | 32'(exp_n[s] - 1));
    end
    $display("done bus16");
  endtask : t_bus16
  task automatic t_writes();
    logic [2:0] bw = 3'b110;
    int exp_oe[3] = '{1, 4, 4};
    int exp_mask[3] = '{0, 0, 3};
    sas_size_t szs[3] = '{SIZE_LONG, SIZE_LINE, SIZE_LONG};
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      burst_write_select <= bw[k];
      bus_width_32 <= 1'b1;
      access(1'b1, szs[k], k[0], 13'h0044);
      check(32'(n_oe), 32'(exp_oe[k]));
      check(32'(n_mask), 32'(exp_mask[k]));
      check(32'(n_act), 32'h1);
      check(wd0, 32'h44C344C3);
    end
    $display("done writes");
  endtask : t_writes
  task automatic t_hold();
    @(posedge clk_sys);
    bank_hold_enable <= 1'b1;
    burst_write_select <= 1'b0;
    access(1'b0, SIZE_LONG, 1'b0, 13'h0100);
    check(32'(bank_open), 32'h1);
    access(1'b1, SIZE_LONG, 1'b0, 13'h0100);
    check(32'(n_act), 32'h0);
    @(posedge clk_sys);
    req_space_two <= 1'b1;
    access(1'b0, SIZE_LONG, 1'b0, 13'h0200);
    check(32'(bank_open), 32'h1);
    @(posedge clk_sys);
    req_space_two <= 1'b0;
    access(1'b0, SIZE_LONG, 1'b0, 13'h0300);
    check(32'(n_cls), 32'h1);
    check(32'(n_act), 32'h1);
    check(32'(act_addr), 32'h0300);
    @(posedge clk_sys);
    refresh_done <= 1'b1;
    @(posedge clk_sys);
    refresh_done <= 1'b0;
    @(negedge clk_sys);
    check(32'(bank_open), 32'h0);
    access(1'b0, SIZE_LONG, 1'b1, 13'h0300);
    check(32'(bank_open), 32'h2);
    @(posedge clk_sys);
    bus_released <= 1'b1;
    @(posedge clk_sys);
    bus_released <= 1'b0;
    @(negedge clk_sys);
    check(32'(bank_open), 32'h0);
    $display("done hold");
  endtask : t_hold
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reads();
    t_bus16();
    t_writes();
    t_hold();
    give_verdict();
  end
endmodule : sas_sequencer_bench
bind sas_sequencer sas_sequencer_properties chk_u (.clk_sys, .resetn, .rd_valid, .req_ready, .burst_write_select,
  .bank_hold_enable, .activate_delay_count, .cas_latency, .bus_width_32, .refresh_done, .bank_open, .sd_cmd,
  .sd_sel_main, .sd_sel_two, .sd_wdata_oe);
